// >>> ltc_tone_control.sv
// tone keying, low-dissipation interlock, lockout and soft-start for the lnb supply
`timescale 1ns/10ps
`include "ltc_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
// Contract
// (RULE1) With external select and tone enable both 1, the tone is keyed from the input pin.
// (RULE2) With external select 0 and tone enable 1, the pin is an envelope gating the tone.
// (RULE3) Continuous tone is had by tone enable alone, pin held high and select 0.
// (RULE4) The host keeps low dissipation at 0 while tone or data is active.
// (RULE5) Low dissipation 1 with tone off selects reduced-headroom regulation.
// (RULE6) In external mode the output follows the pin's frequency and duty.
// (RULE7) The host sets select and enable before driving the external tone.
// (RULE8) In external mode the tone starts about 1 us after pin activity is seen.
// (RULE9) In external mode the tone stops about 60 us after pin activity ceases.
// (RULE10) Everything is disabled while supply is below the 4.7 V lockout.
// (RULE11) Soft-start ramps over 4 ms to 13 V and 6 ms to 18 V.
// (RULE12) In envelope mode tone starts 6 us after rising edge and stops 15-60 us after fall.
// (RULE13) With tone enable 0 no tone reaches the supply output.
module ltc_tone_control (
   // clocking
   input  wire logic                  sys_clk,
   input  wire logic                  rst_n,
   input  wire logic                  clkEn,
   // host control bits
   input  wire ltc_pkg::ltc_ctrl_t    ctrl,
   // pins
   input  wire logic                  toneKeyInput,
   input  wire logic [`LTC_MV_W-1:0]  vccMilliVolt,
   // outputs
   output logic                       toneDrive,
   output logic                       toneActive,
   output logic                       lowHeadroom,
   output logic                       lockout,
   output logic [`LTC_RAMP_W-1:0]     rampLevel,
   output logic                       rampDone
);
   localparam int EXT_ON_CYC  = (`LTC_EXT_ON_NS * `LTC_CLK_MHZ + 999) / 1000;
   localparam int EXT_OFF_CYC = (`LTC_EXT_OFF_NS * `LTC_CLK_MHZ) / 1000;
   localparam int ENV_ON_CYC  = (`LTC_ENV_ON_NS * `LTC_CLK_MHZ + 999) / 1000;
   localparam int ENV_OFF_CYC = (`LTC_ENV_OFF_NS * `LTC_CLK_MHZ + 999) / 1000;
   localparam int SS13_CYC    = `LTC_SS13_US * `LTC_CLK_MHZ;
   localparam int SS18_CYC    = `LTC_SS18_US * `LTC_CLK_MHZ;

   // soft-start cycles per ramp step
   function automatic logic [`LTC_CNT_W-1:0] stepCycles(input logic is18);
      stepCycles = is18 ? `LTC_CNT_W'(SS18_CYC / 255) : `LTC_CNT_W'(SS13_CYC / 255);
   endfunction : stepCycles

   ////////////////////////////////////////////////////////////////////////////
   // pin and supply synchronisation
   logic [1:0] pinSync;
   logic       keySync;
   logic       uvSync;

   ltc_sync #(.W(2)) uPinSync (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .clkEn   (clkEn),
      .asyncIn ({toneKeyInput, vccMilliVolt < `LTC_MV_W'(`LTC_UVLO_MV)}),
      .syncOut (pinSync)
   );
   assign keySync = pinSync[1];
   assign uvSync  = pinSync[0];

   ////////////////////////////////////////////////////////////////////////////
   // mode decode and keying state
   ltc_pkg::ltc_mode_t mode;
   ltc_pkg::ltc_gate_t gate_r, gate_nxt;
   logic [`LTC_CNT_W-1:0] dly_r, dly_nxt;
   logic [`LTC_CNT_W-1:0] gen_r, gen_nxt;
   logic keyPrev_r, keyPrev_nxt;
   logic gen22_r, gen22_nxt;
   logic drive_r, drive_nxt;
   logic edgeSeen;

   // lockout and tone enable gate every mode
   always_comb begin
      if (uvSync || !ctrl.toneEnable) mode = ltc_pkg::LTC_MODE_OFF;        // [RULE10] [RULE13]
      else if (ctrl.extWaveSelect) mode = ltc_pkg::LTC_MODE_EXT;           // [RULE1]
      else mode = ltc_pkg::LTC_MODE_ENV;                                   // [RULE2] [RULE3]
   end

   assign edgeSeen = keySync != keyPrev_r;

   // gate sequencing: on delay, hold-off delay after activity stops
   always_comb begin
      gate_nxt    = gate_r;
      dly_nxt     = dly_r;
      keyPrev_nxt = keySync;
      case (gate_r)
         ltc_pkg::LTC_GATE_IDLE: begin
            dly_nxt = '0;
            if ((mode == ltc_pkg::LTC_MODE_EXT && edgeSeen) ||
                (mode == ltc_pkg::LTC_MODE_ENV && keySync))
               gate_nxt = ltc_pkg::LTC_GATE_ARMING;
         end
         ltc_pkg::LTC_GATE_ARMING: begin
            dly_nxt = dly_r + `LTC_CNT_W'(1);
            if (mode == ltc_pkg::LTC_MODE_OFF ||
                (mode == ltc_pkg::LTC_MODE_ENV && !keySync)) begin
               gate_nxt = ltc_pkg::LTC_GATE_IDLE;
            end else if (mode == ltc_pkg::LTC_MODE_EXT &&
                         dly_r >= `LTC_CNT_W'(EXT_ON_CYC - 1)) begin      // [RULE8]
               gate_nxt = ltc_pkg::LTC_GATE_ON;
               dly_nxt  = '0;
            end else if (mode == ltc_pkg::LTC_MODE_ENV &&
                         dly_r >= `LTC_CNT_W'(ENV_ON_CYC - 1)) begin      // [RULE12]
               gate_nxt = ltc_pkg::LTC_GATE_ON;
               dly_nxt  = '0;
            end
         end
         ltc_pkg::LTC_GATE_ON: begin
            dly_nxt = '0;
            if (mode == ltc_pkg::LTC_MODE_OFF) gate_nxt = ltc_pkg::LTC_GATE_IDLE;
            else if (mode == ltc_pkg::LTC_MODE_EXT ? !edgeSeen : !keySync)
               gate_nxt = ltc_pkg::LTC_GATE_HOLD;
         end
         ltc_pkg::LTC_GATE_HOLD: begin
            dly_nxt = dly_r + `LTC_CNT_W'(1);
            if (mode == ltc_pkg::LTC_MODE_OFF) begin
               gate_nxt = ltc_pkg::LTC_GATE_IDLE;
            end else if (mode == ltc_pkg::LTC_MODE_EXT ? edgeSeen : keySync) begin
               gate_nxt = ltc_pkg::LTC_GATE_ON;                            // activity resumed
               dly_nxt  = '0;
            end else if (mode == ltc_pkg::LTC_MODE_EXT &&
                         dly_r >= `LTC_CNT_W'(EXT_OFF_CYC - 1)) begin     // [RULE9]
               gate_nxt = ltc_pkg::LTC_GATE_IDLE;
            end else if (mode == ltc_pkg::LTC_MODE_ENV &&
                         dly_r >= `LTC_CNT_W'(ENV_OFF_CYC - 1)) begin     // [RULE12]
               gate_nxt = ltc_pkg::LTC_GATE_IDLE;
            end
         end
         default: gate_nxt = ltc_pkg::LTC_GATE_IDLE;
      endcase
   end

   // internal 22 kHz square wave used in envelope mode
   always_comb begin
      gen_nxt   = gen_r + `LTC_CNT_W'(1);
      gen22_nxt = gen22_r;
      if (gen_r >= `LTC_CNT_W'(`LTC_TONE_HALF_CYC - 1)) begin
         gen_nxt   = '0;
         gen22_nxt = !gen22_r;
      end
      // external mode copies the pin so frequency and duty follow it
      drive_nxt = 1'b0;
      if (gate_r == ltc_pkg::LTC_GATE_ON || gate_r == ltc_pkg::LTC_GATE_HOLD) begin
         if (mode == ltc_pkg::LTC_MODE_EXT) drive_nxt = keySync;          // [RULE6]
         else if (mode == ltc_pkg::LTC_MODE_ENV) drive_nxt = gen22_r;     // [RULE2]
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         gate_r    <= ltc_pkg::LTC_GATE_IDLE;
         dly_r     <= '0;
         gen_r     <= '0;
         keyPrev_r <= 1'b0;
         gen22_r   <= 1'b0;
         drive_r   <= 1'b0;
      end else if (clkEn) begin
         gate_r    <= gate_nxt;
         dly_r     <= dly_nxt;
         gen_r     <= gen_nxt;
         keyPrev_r <= keyPrev_nxt;
         gen22_r   <= gen22_nxt;
         drive_r   <= drive_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // headroom selection and tone-active flags
   logic lowHead_r, lowHead_nxt;
   logic active_r, active_nxt;

   // reduced headroom only when tone enable is 0; tone enable overrides a stray bit
   always_comb begin
      active_nxt  = (gate_nxt == ltc_pkg::LTC_GATE_ON ||
                     gate_nxt == ltc_pkg::LTC_GATE_HOLD) && mode != ltc_pkg::LTC_MODE_OFF;
      lowHead_nxt = ctrl.lowDissSelect && !ctrl.toneEnable && !uvSync;     // [RULE5] [RULE4]
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         lowHead_r <= 1'b0;
         active_r  <= 1'b0;
      end else if (clkEn) begin
         lowHead_r <= lowHead_nxt;
         active_r  <= active_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // soft-start ramp of the step-up output
   logic [`LTC_RAMP_W-1:0] ramp_r, ramp_nxt;
   logic [`LTC_CNT_W-1:0]  ssCnt_r, ssCnt_nxt;

   // ramp restarts from zero after lockout or supply off
   always_comb begin
      ramp_nxt  = ramp_r;
      ssCnt_nxt = ssCnt_r;
      if (uvSync || !ctrl.supplyOn) begin                                  // [RULE10]
         ramp_nxt  = `LTC_RAMP_ZERO;
         ssCnt_nxt = '0;
      end else if (ramp_r != `LTC_RAMP_FULL) begin
         if (ssCnt_r >= stepCycles(ctrl.sel18V) - `LTC_CNT_W'(1)) begin    // [RULE11]
            ssCnt_nxt = '0;
            ramp_nxt  = ramp_r + `LTC_RAMP_W'(1);
         end else begin
            ssCnt_nxt = ssCnt_r + `LTC_CNT_W'(1);
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ramp_r  <= `LTC_RAMP_ZERO;
         ssCnt_r <= '0;
      end else if (clkEn) begin
         ramp_r  <= ramp_nxt;
         ssCnt_r <= ssCnt_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign toneDrive   = drive_r;
   assign toneActive  = active_r;
   assign lowHeadroom = lowHead_r;
   assign lockout     = uvSync;
   assign rampLevel   = ramp_r;
   assign rampDone    = ramp_r == `LTC_RAMP_FULL;
endmodule : ltc_tone_control

// >>> ltc_cfg.svh
// timing and width constants for the lnb tone control block
`ifndef LTC_CFG_SVH
`define LTC_CFG_SVH

`define LTC_CLK_MHZ        100
`define LTC_EXT_ON_NS      1000
`define LTC_EXT_OFF_NS     60000
`define LTC_ENV_ON_NS      6000
`define LTC_ENV_OFF_NS     15000
`define LTC_SS13_US        4000
`define LTC_SS18_US        6000
`define LTC_UVLO_MV        4700
`define LTC_TONE_HALF_CYC  2273
`define LTC_CNT_W          20
`define LTC_MV_W           14
`define LTC_RAMP_W         8
`define LTC_RAMP_FULL      8'hFF
`define LTC_RAMP_ZERO      8'h00

`endif

// >>> ltc_pkg.sv
// types shared by the lnb tone control block
package ltc_pkg;
   typedef enum logic [1:0] {
      LTC_MODE_OFF,
      LTC_MODE_EXT,
      LTC_MODE_ENV
   } ltc_mode_t;

   typedef struct packed {
      logic toneEnable;
      logic extWaveSelect;
      logic lowDissSelect;
      logic sel18V;
      logic supplyOn;
   } ltc_ctrl_t;

   typedef enum logic [1:0] {
      LTC_GATE_IDLE,
      LTC_GATE_ARMING,
      LTC_GATE_ON,
      LTC_GATE_HOLD
   } ltc_gate_t;
endpackage : ltc_pkg

// >>> ltc_sync.sv
// two-flop synchroniser for pin-level inputs
`timescale 1ns/10ps
module ltc_sync #(
   parameter int W = 1
) (
   // clocking
   input  wire logic         sys_clk,
   input  wire logic         rst_n,
   input  wire logic         clkEn,
   // data
   input  wire logic [W-1:0] asyncIn,
   output logic      [W-1:0] syncOut
);
   logic [W-1:0] meta_r;
   logic [W-1:0] meta_nxt;
   logic [W-1:0] sync_r;
   logic [W-1:0] sync_nxt;

   // hold while the enable is low
   always_comb begin
      meta_nxt = clkEn ? asyncIn : meta_r;
      sync_nxt = clkEn ? meta_r : sync_r;
   end

   // first stage is read only by the second
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
      end
   end

   assign syncOut = sync_r;
endmodule : ltc_sync

// >>> ltc_tone_control_properties.sv
// port assertions for the lnb tone control block
`timescale 1ns/10ps
`include "ltc_cfg.svh"
module ltc_tone_control_properties (
   // clocking
   input wire logic                     sys_clk,
   input wire logic                     rst_n,
   input wire logic                     clkEn,
   // inputs
   input wire ltc_pkg::ltc_ctrl_t       ctrl,
   input wire logic                     toneKeyInput,
   input wire logic [`LTC_MV_W-1:0]     vccMilliVolt,
   // outputs
   input wire logic                     toneDrive,
   input wire logic                     toneActive,
   input wire logic                     lowHeadroom,
   input wire logic                     lockout,
   input wire logic [`LTC_RAMP_W-1:0]   rampLevel,
   input wire logic                     rampDone
);
   logic [13:0] pinAge_r;
   logic [13:0] pinAge_nxt;
   logic        keyPrev_r;
   wire         extMode = ctrl.toneEnable && ctrl.extWaveSelect && !lockout;
   wire         envMode = ctrl.toneEnable && !ctrl.extWaveSelect && !lockout;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n || !clkEn);
   ////////////////////////////////////////////////////////////////////////////
   // cycles since the last pin change, saturating so it never wraps
   always_comb begin
      pinAge_nxt = (&pinAge_r) ? pinAge_r : pinAge_r + 14'h0001;
      if (toneKeyInput != keyPrev_r) begin
         pinAge_nxt = 14'h0000;
      end
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pinAge_r  <= 14'h3FFF;
         keyPrev_r <= 1'b0;
      end else if (clkEn) begin
         pinAge_r  <= pinAge_nxt;
         keyPrev_r <= toneKeyInput;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   property p_off_disabled;
      !ctrl.toneEnable |-> ##2 (!toneDrive && !toneActive);
   endproperty
   a_off_disabled: assert property (p_off_disabled) else $error("tone while disabled");
   property p_lockout;
      lockout |-> ##2 (!toneDrive && !toneActive);
   endproperty
   a_lockout: assert property (p_lockout) else $error("tone during lockout");
   property p_headroom;
      lowHeadroom == ($past(ctrl.lowDissSelect) && !$past(ctrl.toneEnable) && !$past(lockout));
   endproperty
   a_headroom: assert property (p_headroom) else $error("headroom select wrong");
   property p_ext_on;
      $rose(toneActive) && extMode |-> pinAge_r >= 14'd95 && pinAge_r <= 14'd110;
   endproperty
   a_ext_on: assert property (p_ext_on) else $error("ext start delay wrong");
   property p_ext_off;
      $fell(toneActive) && extMode && $past(ctrl.toneEnable) |-> pinAge_r >= 14'd5990
         && pinAge_r <= 14'd6015;
   endproperty
   a_ext_off: assert property (p_ext_off) else $error("ext stop delay wrong");
   property p_env_on;
      $rose(toneActive) && envMode |-> toneKeyInput && pinAge_r >= 14'd590 && pinAge_r <= 14'd615;
   endproperty
   a_env_on: assert property (p_env_on) else $error("env start delay wrong");
   property p_env_off;
      $fell(toneActive) && envMode && $past(ctrl.toneEnable) |-> !toneKeyInput
         && pinAge_r >= 14'd1490 && pinAge_r <= 14'd1515;
   endproperty
   a_env_off: assert property (p_env_off) else $error("env stop delay wrong");
   property p_follow;
      extMode && toneActive && $past(toneActive, 3) && $changed(toneDrive) |->
         toneDrive == toneKeyInput && pinAge_r <= 14'd6;
   endproperty
   a_follow: assert property (p_follow) else $error("drive not following pin");
   property p_ramp_lock;
      lockout |=> rampLevel == 8'h00;
   endproperty
   a_ramp_lock: assert property (p_ramp_lock) else $error("ramp held in lockout");
   property p_ramp_step;
      $changed(rampLevel) && rampLevel != 8'h00 |-> rampLevel == $past(rampLevel) + 8'h01;
   endproperty
   a_ramp_step: assert property (p_ramp_step) else $error("ramp step not one");
endmodule : ltc_tone_control_properties

bind ltc_tone_control ltc_tone_control_properties u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
   .clkEn(clkEn), .ctrl(ctrl), .toneKeyInput(toneKeyInput), .vccMilliVolt(vccMilliVolt),
   .toneDrive(toneDrive), .toneActive(toneActive), .lowHeadroom(lowHeadroom),
   .lockout(lockout), .rampLevel(rampLevel), .rampDone(rampDone));

// >>> ltc_tone_source.sv
// tone modulator model driving the key pin
`timescale 1ns/10ps
module ltc_tone_source #(
   parameter int HALF = 400
) (
   // clocking
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   // 0 idle low, 1 burst, 2 level high
   input  wire logic [1:0] mode,
   // key pin
   output logic            key
);
   int cnt;
   // burst is a square that toggles every HALF cycles; each edge restarts the hold timer in external mode
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         key <= 1'b0;
         cnt <= 0;
      end else if (mode == 2'h1) begin
         cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
         if (cnt == HALF - 1) key <= ~key;
      end else begin
         key <= (mode == 2'h2);
         cnt <= 0;
      end
   end
endmodule : ltc_tone_source

// >>> ltc_tone_control_bench.sv
// self-checking bench for the lnb tone control block
`timescale 1ns/10ps
`include "ltc_cfg.svh"
module ltc_tone_control_bench;
   typedef struct packed {
      logic [4:0] c;
      logic [1:0] m;
      logic       on;
      logic       hdr;
   } ltc_row_t;
   logic                     sys_clk;
   logic                     rst_n;
   logic                     clkEn;
   ltc_pkg::ltc_ctrl_t       ctrl;
   logic [1:0]               srcMode;
   logic                     toneKeyInput;
   logic [`LTC_MV_W-1:0]     vccMilliVolt;
   logic                     toneDrive;
   logic                     toneActive;
   logic                     lowHeadroom;
   logic                     lockout;
   logic [`LTC_RAMP_W-1:0]   rampLevel;
   logic                     rampDone;
   int                       badCount;
   int                       checks;
   logic                     toneSave;
   logic [`LTC_RAMP_W-1:0]   rampSave;
   // ctrl is {enable, ext, lowdiss, sel18, supply}; low dissipation only with tone off
   ltc_row_t rows [7] = '{'{5'h19, 2'h1, 1'b1, 1'b0}, '{5'h11, 2'h2, 1'b1, 1'b0},
      '{5'h09, 2'h1, 1'b0, 1'b0}, '{5'h01, 2'h2, 1'b0, 1'b0}, '{5'h05, 2'h0, 1'b0, 1'b1},
      '{5'h11, 2'h0, 1'b0, 1'b0}, '{5'h1B, 2'h1, 1'b1, 1'b0}};
   ////////////////////////////////////////////////////////////////////////////
   ltc_tone_control dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn), .ctrl(ctrl),
      .toneKeyInput(toneKeyInput), .vccMilliVolt(vccMilliVolt), .toneDrive(toneDrive),
      .toneActive(toneActive), .lowHeadroom(lowHeadroom), .lockout(lockout),
      .rampLevel(rampLevel), .rampDone(rampDone));
   // the modulator keys at the real 22 kHz rate
   ltc_tone_source #(.HALF(`LTC_TONE_HALF_CYC)) src_u (.sys_clk(sys_clk), .rst_n(rst_n),
      .mode(srcMode), .key(toneKeyInput));
   ////////////////////////////////////////////////////////////////////////////
   task automatic waitCyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : waitCyc
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         badCount++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic stopTest;
      if (badCount == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : stopTest
   // clock at 100 MHz
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // watchdog well past the expected run length
   initial begin
      waitCyc(90000);
      badCount++;
      stopTest();
   end
   // main sequence: table rows first, then ramp, reset, continuous tone, lockout and ramp freeze
   initial begin
      badCount = 0;
      checks = 0;
      rst_n = 1'b0;
      clkEn = 1'b1;
      ctrl = 5'h01;
      srcMode = 2'h0;
      vccMilliVolt = 14'h2EE0;
      waitCyc(10);
      rst_n <= 1'b1;
      foreach (rows[i]) begin
         ctrl <= rows[i].c;
         waitCyc(20);
         srcMode <= rows[i].m;
         waitCyc(2600);
         chk("toneActive", rows[i].on, toneActive);
         chk("lowHeadroom", rows[i].hdr, lowHeadroom);
         srcMode <= 2'h0;
         waitCyc(1400);
         chk("toneHold", rows[i].on, toneActive);
         waitCyc(6200);
         chk("toneOff", 8'h00, toneActive);
      end
      // about 71k cycles in, the ramp has climbed but not finished
      chk("rampMoving", 8'h01, rampLevel != 8'h00);
      chk("rampDone", 8'h00, rampDone);
      // mid-run reset while the ramp is up, so the clear is visible
      rst_n <= 1'b0;
      waitCyc(2);
      chk("rstRamp", 8'h00, rampLevel);
      chk("rstLock", 8'h00, lockout);
      rst_n <= 1'b1;
      waitCyc(2);
      // continuous tone: envelope held high, internal square must toggle
      ctrl <= 5'h11;
      srcMode <= 2'h2;
      waitCyc(700);
      chk("lockPre", 8'h01, toneActive);
      toneSave = toneDrive;
      waitCyc(`LTC_TONE_HALF_CYC);
      chk("toneWave", {7'h00, !toneSave}, toneDrive);
      vccMilliVolt <= 14'h0FA0;
      waitCyc(10);
      chk("lockout", 8'h01, lockout);
      chk("lockTone", 8'h00, toneActive);
      chk("lockDrive", 8'h00, toneDrive);
      chk("lockRamp", 8'h00, rampLevel);
      srcMode <= 2'h0;
      vccMilliVolt <= 14'h2EE0;
      waitCyc(10);
      chk("unlock", 8'h00, lockout);
      // enable low for longer than one ramp step must freeze the ramp
      rampSave = rampLevel;
      clkEn <= 1'b0;
      waitCyc(1600);
      chk("freezeRamp", rampSave, rampLevel);
      clkEn <= 1'b1;
      waitCyc(2);
      stopTest();
   end
endmodule : ltc_tone_control_bench
